// ### verilog/spr_setpoint_ramp_select.sv
// How it works
// - while ramping, control uses the rate-limited working set point
// - ramping on when rise or fall rate nonzero; zero frees direction
// - time unit 0 is seconds, 1 is minutes, default minutes
// - rise and fall rates per bank, 0 to 9999, default zero
// - time-unit writes accepted only while stopped
// - working set point readable, -1999 to 9999
// - stop-to-run with ramping ramps working set point toward target
// - autotuning start waits until any ramp reaches its target
// - manual output mode keeps the ramp advancing
// - stop or channel error cancels ramp limiting
// - ramping needs self-tuning off; remote enable forces it off
// - remote enable 0 off 1 on, default off, applies after reset
// - remote set point is the source channel's live process value
// - local set point is the selected bank's set point
// - assigned event input off selects local, on selects remote
// - remote value clamped to input range and set-point limits
// - tuning under remote uses latched set point, then follows remote
// - remote-to-local with tracking copies remote into local
// - local-to-remote with ramping ramps toward remote value
// - tracking 0 off 1 on, default 0, remote only, stopped writes
// - remote offered on channels 1-2 of four, channel 1 of two
// - control set point limited to narrower of range and limits
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "spr_consts.svh"

module spr_setpoint_ramp_select #(
    parameter int NUM_BANKS    = 8,
    parameter int CHANNEL      = 1,
    parameter bit FOUR_CHANNEL = 1'b1,
    parameter int TICK_CYCLES  = `SPR_SECOND_NS / `SPR_CLK_NS
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    input  wire logic                      eventIn,
    input  wire logic signed [15:0]        processValue,
    input  wire logic signed [15:0]        remoteProcessValue,
    input  wire logic                      channelError,
    input  wire logic                      autoTuneDone,
    output logic signed [15:0]             workingSetpoint,
    output spr_pkg::sprStatus_type         status
);

    localparam int BW = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic bankHit(input logic [7:0] a);
        bankHit = a[7] && (32'(a[6:4]) < NUM_BANKS) && (a[3:2] != 2'h3);
    endfunction

    function automatic logic signed [15:0] clampSp(
        input logic signed [15:0] v,
        input logic signed [15:0] lo,
        input logic signed [15:0] hi
    );
        if (v < lo) begin
            clampSp = lo;
        end else if (v > hi) begin
            clampSp = hi;
        end else begin
            clampSp = v;
        end
    endfunction

    function automatic logic [13:0] satRate(input logic [15:0] d);
        satRate = (d > 16'(`SPR_RATE_MAX)) ? `SPR_RATE_MAX : d[13:0];
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    spr_pkg::sprCtrl_type  ctrl;
    spr_pkg::sprMode_type  mode;
    spr_pkg::sprMode_type  next_mode;
    logic                  timeUnit;
    logic                  tracking;
    logic                  remEnPending;
    logic                  remEnEffective;
    logic [BW-1:0]         bankSel;
    logic signed [15:0]    limUpper;
    logic signed [15:0]    limLower;
    logic signed [15:0]    rangeHi;
    logic signed [15:0]    rangeLo;
    logic signed [15:0]    bankSp   [NUM_BANKS];
    logic [13:0]           bankRise [NUM_BANKS];
    logic [13:0]           bankFall [NUM_BANKS];
    logic                  atPending;
    logic signed [15:0]    atSetpoint;
    logic                  runPrev;
    logic                  remotePrev;
    logic                  evtMeta;
    logic                  evtSync;
    logic [31:0]           secCount;
    logic [5:0]            minCount;
    logic [7:0]            addrQ;
    logic                  writeQ;
    logic                  validQ;
    logic signed [15:0]    next_working;

    // ----------------------------------------------------------------
    // derived terms
    // ----------------------------------------------------------------
    logic                  busWrite;
    logic                  runStart;
    logic                  remoteAllowed;
    logic                  remoteActive;
    logic                  selfTuneOn;
    logic                  rampOn;
    logic                  rampBusy;
    logic                  trackLoad;
    logic                  atStartWr;
    logic                  secTick;
    logic                  unitTick;
    logic signed [15:0]    effHi;
    logic signed [15:0]    effLo;
    logic signed [15:0]    spHi;
    logic signed [15:0]    spLo;
    logic signed [15:0]    localTarget;
    logic signed [15:0]    remoteTarget;
    logic signed [15:0]    target;
    logic signed [16:0]    diff;
    logic signed [16:0]    riseS;
    logic signed [16:0]    fallS;
    logic signed [16:0]    stepSum;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign busWrite  = validQ && writeQ;
    assign runStart  = ctrl.run && !runPrev;
    assign atStartWr = busWrite && (addrQ == `SPR_OFS_CTRL)
                       && hwdata[`SPR_CTRL_ATSTART];

    assign remoteAllowed = remEnEffective
                           && ((CHANNEL == 1)
                               || (FOUR_CHANNEL && (CHANNEL == 2)));
    assign remoteActive  = remoteAllowed
                           && (ctrl.evtAssign ? evtSync : ctrl.remoteSel);
    assign selfTuneOn    = ctrl.selfTune && !remEnEffective;

    assign effHi = (limUpper > limLower) ? limUpper : limLower;
    assign effLo = (limUpper > limLower) ? limLower : limUpper;
    assign spHi  = (effHi < rangeHi) ? effHi : rangeHi;
    assign spLo  = (effLo > rangeLo) ? effLo : rangeLo;

    assign localTarget  = clampSp(bankSp[bankSel], spLo, spHi);
    assign remoteTarget = clampSp(remoteProcessValue, spLo, spHi);
    assign target = (mode == spr_pkg::SPR_TUNING) ? atSetpoint :
                    remoteActive ? remoteTarget : localTarget;

    assign rampOn = ((bankRise[bankSel] != 14'h0000)
                     || (bankFall[bankSel] != 14'h0000))
                    && !selfTuneOn && !channelError
                    && ctrl.run; // on in the run-edge cycle too
    assign rampBusy = rampOn && (workingSetpoint != target);

    assign trackLoad = remotePrev && !remoteActive && tracking
                       && remoteAllowed;

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    // address phase capture
    always_ff @(posedge clk) begin
        if (rst) begin
            validQ <= 1'b0;
            writeQ <= 1'b0;
            addrQ  <= 8'h00;
        end else if (hready) begin
            validQ <= hsel && htrans[1];
            writeQ <= hwrite;
            addrQ  <= haddr[7:0];
        end
    end

    // read data registered at address phase
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            if (haddr[7:0] == `SPR_OFS_CTRL) begin
                hrdata <= {26'h000_0000, ctrl.selfTune, ctrl.evtAssign,
                           atPending, ctrl.remoteSel, ctrl.manual,
                           ctrl.run};
            end else if (haddr[7:0] == `SPR_OFS_CONFIG) begin
                hrdata <= {29'h0000_0000, remEnPending, tracking,
                           timeUnit};
            end else if (haddr[7:0] == `SPR_OFS_BANKSEL) begin
                hrdata <= {{(32-BW){1'b0}}, bankSel};
            end else if (haddr[7:0] == `SPR_OFS_SPLIMIT) begin
                hrdata <= {limUpper, limLower};
            end else if (haddr[7:0] == `SPR_OFS_INRANGE) begin
                hrdata <= {rangeHi, rangeLo};
            end else if (haddr[7:0] == `SPR_OFS_WORKSP) begin
                hrdata <= {16'h0000, workingSetpoint};
            end else if (haddr[7:0] == `SPR_OFS_LOCALMON) begin
                hrdata <= {16'h0000, localTarget};
            end else if (haddr[7:0] == `SPR_OFS_REMOTEMON) begin
                hrdata <= {16'h0000, remoteTarget};
            end else if (haddr[7:0] == `SPR_OFS_STATUS) begin
                hrdata <= {26'h000_0000, remEnEffective, mode,
                           selfTuneOn, remoteActive, rampBusy};
            end else if (bankHit(haddr[7:0])) begin
                if (haddr[3:2] == `SPR_OFS_BANK_SP) begin
                    hrdata <= {16'h0000, bankSp[haddr[4+:BW]]};
                end else if (haddr[3:2] == `SPR_OFS_BANK_RISE) begin
                    hrdata <= {18'h0_0000, bankRise[haddr[4+:BW]]};
                end else begin
                    hrdata <= {18'h0_0000, bankFall[haddr[4+:BW]]};
                end
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // control and configuration registers
    // ----------------------------------------------------------------
    // control word
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= '0;
        end else if (busWrite && (addrQ == `SPR_OFS_CTRL)) begin
            ctrl.run       <= hwdata[`SPR_CTRL_RUN];
            ctrl.manual    <= hwdata[`SPR_CTRL_MANUAL];
            ctrl.remoteSel <= hwdata[`SPR_CTRL_REMSEL];
            ctrl.evtAssign <= hwdata[`SPR_CTRL_EVTASSGN];
            ctrl.selfTune  <= hwdata[`SPR_CTRL_SELFTUNE];
        end
    end

    // configuration, unit and tracking locked during run
    always_ff @(posedge clk) begin
        if (rst) begin
            timeUnit     <= `SPR_UNIT_RESET;
            tracking     <= 1'b0;
            remEnPending <= 1'b0;
        end else if (busWrite && (addrQ == `SPR_OFS_CONFIG)) begin
            remEnPending <= hwdata[`SPR_CFG_REMEN];
            if (!ctrl.run && (mode == spr_pkg::SPR_STOPPED)) begin
                timeUnit <= hwdata[`SPR_CFG_UNIT];
                tracking <= hwdata[`SPR_CFG_TRACK];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            remEnEffective <= 1'b0;
        end else if (busWrite && (addrQ == `SPR_OFS_SOFTRST)
                     && hwdata[0]) begin
            remEnEffective <= remEnPending;
        end
    end

    // bank select, limits and input range
    always_ff @(posedge clk) begin
        if (rst) begin
            bankSel  <= '0;
            limUpper <= `SPR_SP_MAX;
            limLower <= `SPR_SP_MIN;
            rangeHi  <= `SPR_SP_MAX;
            rangeLo  <= `SPR_SP_MIN;
        end else if (busWrite) begin
            if (addrQ == `SPR_OFS_BANKSEL) begin
                bankSel <= hwdata[BW-1:0];
            end else if (addrQ == `SPR_OFS_SPLIMIT) begin
                limUpper <= hwdata[31:16];
                limLower <= hwdata[15:0];
            end else if (addrQ == `SPR_OFS_INRANGE) begin
                rangeHi <= hwdata[31:16];
                rangeLo <= hwdata[15:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // bank memory
    // ----------------------------------------------------------------
    // per-bank set points and rates
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_BANKS; i++) begin
                bankSp[i]   <= `SPR_SP_RESET;
                bankRise[i] <= 14'h0000;
                bankFall[i] <= 14'h0000;
            end
        end else begin
            if (busWrite && bankHit(addrQ)) begin
                if (addrQ[3:2] == `SPR_OFS_BANK_SP) begin
                    bankSp[addrQ[4+:BW]] <= hwdata[15:0];
                end else if (addrQ[3:2] == `SPR_OFS_BANK_RISE) begin
                    bankRise[addrQ[4+:BW]] <= satRate(hwdata[15:0]);
                end else begin
                    bankFall[addrQ[4+:BW]] <= satRate(hwdata[15:0]);
                end
            end
            if (trackLoad) begin
                bankSp[bankSel] <= remoteTarget;
            end
        end
    end

    // ----------------------------------------------------------------
    // event input synchroniser and edge history
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            evtMeta    <= 1'b0;
            evtSync    <= 1'b0;
            runPrev    <= 1'b0;
            remotePrev <= 1'b0;
        end else begin
            evtMeta    <= eventIn;
            evtSync    <= evtMeta;
            runPrev    <= ctrl.run;
            remotePrev <= remoteActive;
        end
    end

    // ----------------------------------------------------------------
    // time base
    // ----------------------------------------------------------------
    assign secTick  = (secCount == 32'(TICK_CYCLES - 1));
    assign unitTick = timeUnit ? (secTick && (minCount == `SPR_MIN_SECONDS))
                               : secTick;

    // second and minute counters restart with each run
    always_ff @(posedge clk) begin
        if (rst || runStart) begin
            secCount <= 32'h0000_0000;
            minCount <= 6'h00;
        end else if (secTick) begin
            secCount <= 32'h0000_0000;
            minCount <= (minCount == `SPR_MIN_SECONDS) ? 6'h00
                                                      : minCount + 6'h01;
        end else begin
            secCount <= secCount + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // mode machine and autotuning hold-off
    // ----------------------------------------------------------------
    always_comb begin
        next_mode = mode;
        case (mode)
            spr_pkg::SPR_STOPPED: begin
                if (ctrl.run) begin
                    next_mode = spr_pkg::SPR_RUNNING;
                end
            end
            spr_pkg::SPR_RUNNING: begin
                if (!ctrl.run) begin
                    next_mode = spr_pkg::SPR_STOPPED;
                end else if (atPending && !ctrl.manual && !rampBusy
                             && !channelError) begin
                    next_mode = spr_pkg::SPR_TUNING;
                end
            end
            spr_pkg::SPR_TUNING: begin
                if (!ctrl.run) begin
                    next_mode = spr_pkg::SPR_STOPPED;
                end else if (autoTuneDone) begin
                    next_mode = spr_pkg::SPR_RUNNING;
                end
            end
            default: begin
                next_mode = spr_pkg::SPR_STOPPED;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= spr_pkg::SPR_STOPPED;
        end else begin
            mode <= next_mode;
        end
    end

    // pending request; a new request beats a same-cycle clear
    always_ff @(posedge clk) begin
        if (rst) begin
            atPending <= 1'b0;
        end else if (atStartWr && ctrl.run) begin
            atPending <= 1'b1;
        end else if (!ctrl.run || (next_mode == spr_pkg::SPR_TUNING)) begin
            atPending <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            atSetpoint <= `SPR_SP_RESET;
        end else if ((mode == spr_pkg::SPR_RUNNING)
                     && (next_mode == spr_pkg::SPR_TUNING)) begin
            atSetpoint <= target;
        end
    end

    // ----------------------------------------------------------------
    // ramp engine
    // ----------------------------------------------------------------
    assign diff  = {target[15], target}
                   - {workingSetpoint[15], workingSetpoint};
    assign riseS = {3'b000, bankRise[bankSel]};
    assign fallS = {3'b000, bankFall[bankSel]};

    always_comb begin
        next_working = workingSetpoint;
        stepSum      = {workingSetpoint[15], workingSetpoint};
        if (!rampOn) begin
            next_working = target;
        end else if (runStart) begin
            next_working = clampSp(processValue, spLo, spHi);
        end else if (unitTick) begin
            if (diff > 17'sd0) begin
                stepSum = stepSum + riseS;
                if ((riseS == 17'sd0) || (diff <= riseS)) begin
                    next_working = target;
                end else begin
                    next_working = stepSum[15:0];
                end
            end else if (diff < 17'sd0) begin
                stepSum = stepSum - fallS;
                if ((fallS == 17'sd0) || (-diff <= fallS)) begin
                    next_working = target;
                end else begin
                    next_working = stepSum[15:0];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            workingSetpoint <= `SPR_SP_RESET;
        end else begin
            workingSetpoint <= next_working;
        end
    end

    // status flags
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= '0;
        end else begin
            status.rampActive   <= rampBusy;
            status.remoteActive <= remoteActive;
            status.tuning       <= (next_mode == spr_pkg::SPR_TUNING);
            status.selfTuneOn   <= selfTuneOn;
        end
    end

endmodule

`default_nettype wire

// ### verilog/spr_consts.svh
`ifndef SPR_CONSTS_SVH
`define SPR_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SPR_OFS_CTRL      8'h00
`define SPR_OFS_CONFIG    8'h04
`define SPR_OFS_BANKSEL   8'h08
`define SPR_OFS_SPLIMIT   8'h0c
`define SPR_OFS_INRANGE   8'h10
`define SPR_OFS_SOFTRST   8'h14
`define SPR_OFS_WORKSP    8'h18
`define SPR_OFS_LOCALMON  8'h1c
`define SPR_OFS_REMOTEMON 8'h20
`define SPR_OFS_STATUS    8'h24
`define SPR_OFS_BANK_SP   2'h0
`define SPR_OFS_BANK_RISE 2'h1
`define SPR_OFS_BANK_FALL 2'h2

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SPR_CTRL_RUN      0
`define SPR_CTRL_MANUAL   1
`define SPR_CTRL_REMSEL   2
`define SPR_CTRL_ATSTART  3
`define SPR_CTRL_EVTASSGN 4
`define SPR_CTRL_SELFTUNE 5
`define SPR_CFG_UNIT      0
`define SPR_CFG_TRACK     1
`define SPR_CFG_REMEN     2

// ----------------------------------------------------------------
// reset values and ranges
// ----------------------------------------------------------------
`define SPR_UNIT_RESET    1'b1
`define SPR_SP_MIN        16'hf831
`define SPR_SP_MAX        16'h270f
`define SPR_RATE_MAX      14'h270f
`define SPR_SP_RESET      16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SPR_SECOND_NS     1000000000
`define SPR_CLK_NS        5
`define SPR_MIN_SECONDS   6'h3b

`endif

// ### verilog/spr_pkg.sv
package spr_pkg;

    // channel operating mode
    typedef enum logic [1:0] {
        SPR_STOPPED = 2'b00,
        SPR_RUNNING = 2'b01,
        SPR_TUNING  = 2'b10
    } sprMode_type;

    // software control bits
    typedef struct packed {
        logic selfTune;
        logic evtAssign;
        logic remoteSel;
        logic manual;
        logic run;
    } sprCtrl_type;

    // channel status seen by the rest of the controller
    typedef struct packed {
        logic selfTuneOn;
        logic tuning;
        logic remoteActive;
        logic rampActive;
    } sprStatus_type;

endpackage

// ### dv/spr_sva.sv
`timescale 1ns/1ps
`default_nettype none
module spr_sva (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   hreadyout,
    input wire logic                   hresp,
    input wire logic                   channelError,
    input wire logic signed [15:0]     workingSetpoint,
    input wire spr_pkg::sprStatus_type status
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    sp_range_a: assert property (workingSetpoint >= $signed(16'hf831) &&
        workingSetpoint <= $signed(16'h270f)) else $error("sp out of range");
    err_cancel_a: assert property (channelError[*3] |-> !status.rampActive)
        else $error("ramp kept under error");
    tune_wait_a: assert property ($rose(status.tuning) |-> !status.rampActive)
        else $error("tuning began mid ramp");
    tune_no_ramp_a: assert property (status.tuning |-> ##1 !status.rampActive)
        else $error("ramp during tuning");
    remote_no_st_a: assert property (status.remoteActive |-> !status.selfTuneOn)
        else $error("self tuning with remote");
    rst_sp_a: assert property (disable iff (1'b0) rst |=> workingSetpoint == 0)
        else $error("sp not cleared");
    rst_stat_a: assert property (disable iff (1'b0) rst |=> status == '0)
        else $error("status not cleared");
endmodule
bind spr_setpoint_ramp_select spr_sva u_sva (.clk(clk), .rst(rst),
    .hreadyout(hreadyout), .hresp(hresp), .channelError(channelError),
    .workingSetpoint(workingSetpoint), .status(status));
`default_nettype wire

// ### dv/spr_remote_src.sv
`timescale 1ns/1ps
`default_nettype none
module spr_remote_src (
    input  wire logic               clk,
    input  wire logic               selReq,
    input  wire logic signed [15:0] pvReq,
    output logic                    eventIn,
    output logic signed [15:0]      remoteProcessValue
);
    always_ff @(posedge clk) begin
        eventIn            <= selReq;
        remoteProcessValue <= pvReq;
    end
endmodule
`default_nettype wire

// ### dv/tb_setpoint_ramp_select.sv
`timescale 1ns/1ps
`default_nettype none
module tb_setpoint_ramp_select;
    logic               clk, rst, hsel, hwrite, rdPend, selReq, chErr, atDone;
    logic               hready, hresp, evt;
    logic [31:0]        haddr, hwdata, hrdata;
    logic [1:0]         htrans;
    logic [7:0]         seed;
    logic signed [15:0] pv, pvReq, remPv, wsp;
    logic [31:0]        expQ[$];
    spr_pkg::sprStatus_type stat;
    int                 error_cnt, n_checks, cyc;
    spr_setpoint_ramp_select #(.TICK_CYCLES(10)) u_dut (.clk(clk), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .eventIn(evt),
        .processValue(pv), .remoteProcessValue(remPv),
        .channelError(chErr), .autoTuneDone(atDone),
        .workingSetpoint(wsp), .status(stat));
    spr_remote_src u_src (.clk(clk), .selReq(selReq), .pvReq(pvReq),
        .eventIn(evt), .remoteProcessValue(remPv));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one single word transfer, read result noted
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, input logic [31:0] e);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h00_0000, a};
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rdPend <= !w;
        if (!w) expQ.push_back(e);
        do @(posedge clk); while (hready !== 1'b1);
        rdPend <= 1'b0;
    endtask
    // clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // read data compare and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rdPend) check(hrdata, expQ.pop_front());
        if (cyc == 4000) begin
            error_cnt++;
            conclude();
        end
    end
    // main sequence
    initial begin
        {hsel, hwrite, rdPend, selReq, chErr, atDone} = '0;
        {haddr, hwdata, htrans, pvReq, pv} = '0;
        seed = 8'h5b;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        xfer(1'b0, 8'h04, '0, 32'h0000_0001);
        xfer(1'b0, 8'h0c, '0, 32'h270f_f831);
        xfer(1'b0, 8'h7c, '0, 32'h0000_0000);
        $display("reset values done");
        seed = lfsr(seed);
        pv <= {8'h00, seed};
        xfer(1'b1, 8'h04, 32'h0000_0000, '0);
        xfer(1'b1, 8'h84, 32'h0000_0032, '0);
        xfer(1'b1, 8'h80, 32'h0000_03e8, '0);
        xfer(1'b1, 8'h00, 32'h0000_0001, '0);
        xfer(1'b0, 8'h24, '0, 32'h0000_0009);
        repeat (300) @(posedge clk);
        check({16'h0000, wsp}, 32'h0000_03e8);
        xfer(1'b0, 8'h18, '0, 32'h0000_03e8);
        xfer(1'b1, 8'h00, 32'h0000_0009, '0);
        repeat (4) @(posedge clk);
        xfer(1'b0, 8'h24, '0, 32'h0000_0010);
        check({28'h000_0000, stat}, 32'h0000_0004);
        atDone <= 1'b1;
        @(posedge clk);
        atDone <= 1'b0;
        $display("ramp and tuning done");
        chErr <= 1'b1;
        xfer(1'b1, 8'h80, 32'h0000_0bb8, '0);
        repeat (4) @(posedge clk);
        xfer(1'b0, 8'h18, '0, 32'h0000_0bb8);
        xfer(1'b1, 8'h04, 32'h0000_0001, '0);
        xfer(1'b0, 8'h04, '0, 32'h0000_0000);
        xfer(1'b1, 8'h84, 32'h0000_2710, '0);
        xfer(1'b0, 8'h84, '0, 32'h0000_270f);
        $display("error and limits done");
        chErr <= 1'b0;
        seed = lfsr(seed);
        pvReq <= {8'h00, seed};
        xfer(1'b1, 8'h00, 32'h0000_0000, '0);
        xfer(1'b1, 8'h04, 32'h0000_0004, '0);
        xfer(1'b1, 8'h14, 32'h0000_0001, '0);
        xfer(1'b1, 8'h00, 32'h0000_0011, '0);
        selReq <= 1'b1;
        repeat (8) @(posedge clk);
        xfer(1'b0, 8'h20, '0, {24'h00_0000, seed});
        $display("remote done");
        conclude();
    end
endmodule
`default_nettype wire
